// >>> core/count_clock_div.sv
`timescale 1ns/1ns

module count_clock_div
   import timer_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       enable,
   input  wire logic [2:0] clock_select,
   input  wire logic       rl_tick,
   output logic            count_tick
);

   logic [PRESCALE_BITS-1:0] pre_reg;
   logic [PRESCALE_BITS-1:0] pre_next;
   logic [RL_DIV_BITS-1:0]   rl_reg;
   logic [RL_DIV_BITS-1:0]   rl_next;
   logic                     tick_reg;
   logic                     tick_next;

   // true on the last cycle of each 2**n period of the prescaler
   function automatic logic low_ones(input logic [PRESCALE_BITS-1:0] v, input int n);
      logic [PRESCALE_BITS-1:0] mask;
      mask = PRESCALE_BITS'((1 << n) - 1);
      return (v & mask) == mask;
   endfunction

   always_comb begin
      // held clear while stopped so the first tick comes one full period after start
      pre_next  = enable ? pre_reg + 1'b1 : '0;
      rl_next   = rl_reg;
      if (!enable) begin
         rl_next = '0;
      end else if (rl_tick) begin
         rl_next = rl_reg + 1'b1;
      end
      tick_next = 1'b0;
      unique case (clock_select)
         CKS_DIV1:    tick_next = 1'b1;
         CKS_DIV4:    tick_next = low_ones(pre_reg, SHIFT_DIV4);
         CKS_DIV16:   tick_next = low_ones(pre_reg, SHIFT_DIV16);
         CKS_DIV64:   tick_next = low_ones(pre_reg, SHIFT_DIV64);
         CKS_DIV4096: tick_next = low_ones(pre_reg, SHIFT_DIV4096);
         CKS_RL128:   tick_next = rl_tick && (&rl_reg);
         default:     tick_next = 1'b0;
      endcase
      tick_next = tick_next && enable;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_reg  <= '0;
         rl_reg   <= '0;
         tick_reg <= 1'b0;
      end else begin
         pre_reg  <= pre_next;
         rl_reg   <= rl_next;
         tick_reg <= tick_next;
      end
   end

   assign count_tick = tick_reg;

endmodule

// >>> core/interval_pwm_timer_8bit.sv
`timescale 1ns/1ns

module interval_pwm_timer_8bit
   import timer_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [15:0]           bus_addr,
   input  wire logic                  bus_wr,
   input  wire logic [7:0]            bus_wdata,
   input  wire logic                  bus_rd,
   input  wire logic                  rl_tick,
   output logic      [7:0]            bus_rdata,
   output logic                       match_interrupt,
   output logic                       timer_output_pin,
   output logic      [PORT_WIDTH-1:0] port_four_out,
   output logic      [PORT_WIDTH-1:0] port_four_oe
);

   // software registers
   logic [7:0]            cycle_compare_reg;
   logic [7:0]            cycle_compare_next;
   logic [7:0]            duty_compare_reg;
   logic [7:0]            duty_compare_next;
   logic [7:0]            timer_mode_control_reg;
   logic [7:0]            timer_mode_control_next;
   logic [7:0]            port_four_direction_reg;
   logic [7:0]            port_four_direction_next;
   logic [7:0]            port_four_latch_reg;
   logic [7:0]            port_four_latch_next;
   logic [7:0]            rdata_reg;
   logic [7:0]            rdata_next;

   // timer state
   run_state_e            state_reg;
   run_state_e            state_next;
   logic [7:0]            counter_reg;
   logic [7:0]            counter_next;
   logic [7:0]            active_duty_reg;
   logic [7:0]            active_duty_next;
   logic                  duty_pending_reg;
   logic                  duty_pending_next;
   logic [1:0]            duty_age_reg;
   logic [1:0]            duty_age_next;
   logic                  compare_duty_reg;
   logic                  compare_duty_next;
   logic                  out_active_reg;
   logic                  out_active_next;
   logic                  irq_reg;
   logic                  irq_next;
   logic                  pin_reg;
   logic                  pin_next;
   logic [PORT_WIDTH-1:0] port_out_reg;
   logic [PORT_WIDTH-1:0] port_out_next;
   logic [PORT_WIDTH-1:0] port_oe_reg;
   logic [PORT_WIDTH-1:0] port_oe_next;

   logic                  count_tick;
   logic                  run;
   logic                  pwm_mode;
   logic                  write_duty;
   logic                  cycle_match;
   logic                  duty_match;

   assign run        = timer_mode_control_reg[RUN_BIT];
   assign pwm_mode   = timer_mode_control_reg[OPM_MSB];
   assign write_duty = bus_wr && (bus_addr == ADDR_DUTY);

   count_clock_div u_div (
      .clk          (clk),
      .rst_b        (rst_b),
      .enable       (run),
      .clock_select (timer_mode_control_reg[CKS_MSB:CKS_LSB]),
      .rl_tick      (rl_tick),
      .count_tick   (count_tick)
   );

   // register file: writes and registered read data
   always_comb begin
      cycle_compare_next       = cycle_compare_reg;
      duty_compare_next        = duty_compare_reg;
      timer_mode_control_next  = timer_mode_control_reg;
      port_four_direction_next = port_four_direction_reg;
      port_four_latch_next     = port_four_latch_reg;
      rdata_next               = rdata_reg;
      if (bus_wr) begin
         unique case (bus_addr)
            ADDR_CYCLE: cycle_compare_next       = bus_wdata;
            ADDR_DUTY:  duty_compare_next        = bus_wdata;
            ADDR_MODE:  timer_mode_control_next  = bus_wdata;
            ADDR_DIR:   port_four_direction_next = bus_wdata;
            ADDR_LAT:   port_four_latch_next     = bus_wdata;
            default:    ;
         endcase
      end
      if (bus_rd) begin
         unique case (bus_addr)
            ADDR_CYCLE: rdata_next = cycle_compare_reg;
            ADDR_DUTY:  rdata_next = duty_compare_reg;
            ADDR_MODE:  rdata_next = timer_mode_control_reg;
            ADDR_DIR:   rdata_next = port_four_direction_reg;
            ADDR_LAT:   rdata_next = port_four_latch_reg;
            default:    rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cycle_compare_reg       <= CMP_RESET;
         duty_compare_reg        <= CMP_RESET;
         timer_mode_control_reg  <= MODE_RESET;
         port_four_direction_reg <= DIR_RESET;
         port_four_latch_reg     <= LAT_RESET;
         rdata_reg               <= 8'h00;
      end else begin
         cycle_compare_reg       <= cycle_compare_next;
         duty_compare_reg        <= duty_compare_next;
         timer_mode_control_reg  <= timer_mode_control_next;
         port_four_direction_reg <= port_four_direction_next;
         port_four_latch_reg     <= port_four_latch_next;
         rdata_reg               <= rdata_next;
      end
   end

   // interval mode never looks at the duty side
   assign cycle_match = (counter_reg == cycle_compare_reg) && !(pwm_mode && compare_duty_reg);
   assign duty_match  = pwm_mode && compare_duty_reg && (counter_reg == active_duty_reg);

   // counter, compare selection, duty shadow and output state
   always_comb begin
      state_next        = state_reg;
      counter_next      = counter_reg;
      active_duty_next  = active_duty_reg;
      duty_pending_next = duty_pending_reg;
      duty_age_next     = duty_age_reg;
      compare_duty_next = compare_duty_reg;
      out_active_next   = out_active_reg;
      irq_next          = 1'b0;

      // stopped writes load straight through, so a restart runs on the new value from its first period
      if (write_duty) begin
         if (state_reg == run_stopped) begin
            active_duty_next  = bus_wdata;
            duty_pending_next = 1'b0;
         end else begin
            duty_pending_next = 1'b1;
            duty_age_next     = 2'h0;
         end
      end else if (count_tick && duty_pending_reg && duty_age_reg != DUTY_XFER_TICKS) begin
         duty_age_next = duty_age_reg + 2'h1;
      end

      if (!run) begin
         state_next        = run_stopped;
         counter_next      = 8'h00;
         compare_duty_next = 1'b0;
         out_active_next   = 1'b0;
      end else begin
         unique case (state_reg)
            run_stopped: begin
               // pwm burns its first count clock, interval counts at once
               state_next = pwm_mode ? run_masked : run_counting;
            end
            run_masked: begin
               if (count_tick) begin
                  state_next = run_counting;
               end
            end
            run_counting: begin
               if (count_tick) begin
                  if (cycle_match) begin
                     counter_next = 8'h00;
                     irq_next     = 1'b1;
                     if (pwm_mode) begin
                        out_active_next   = 1'b1;
                        compare_duty_next = 1'b1;
                     end else begin
                        out_active_next = !out_active_reg;
                     end
                  end else if (duty_match) begin
                     counter_next      = counter_reg + 8'h01;
                     out_active_next   = 1'b0;
                     compare_duty_next = 1'b0;
                     // a write landing on the match cycle wins and the transfer waits
                     if (duty_pending_reg && !write_duty &&
                         duty_age_reg == DUTY_XFER_TICKS) begin
                        active_duty_next  = duty_compare_reg;
                        duty_pending_next = 1'b0;
                     end
                  end else begin
                     counter_next = counter_reg + 8'h01;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg        <= run_stopped;
         counter_reg      <= 8'h00;
         active_duty_reg  <= CMP_RESET;
         duty_pending_reg <= 1'b0;
         duty_age_reg     <= 2'h0;
         compare_duty_reg <= 1'b0;
         out_active_reg   <= 1'b0;
         irq_reg          <= 1'b0;
      end else begin
         state_reg        <= state_next;
         counter_reg      <= counter_next;
         active_duty_reg  <= active_duty_next;
         duty_pending_reg <= duty_pending_next;
         duty_age_reg     <= duty_age_next;
         compare_duty_reg <= compare_duty_next;
         out_active_reg   <= out_active_next;
         irq_reg          <= irq_next;
      end
   end

   // pins: timer pin computed from next state so it moves on the same edge as the counter; other port bits come from the current latch register
   always_comb begin
      pin_next = timer_mode_control_reg[LEVEL_BIT];
      if (timer_mode_control_reg[GATE_BIT]) begin
         pin_next = timer_mode_control_reg[LEVEL_BIT] ^ out_active_next;
      end
      port_out_next            = port_four_latch_reg[PORT_WIDTH-1:0];
      // timer shares bit 2 by or-ing, so the latch must be low to see it
      port_out_next[TIMER_PIN] = port_four_latch_reg[TIMER_PIN] | pin_next;
      port_oe_next             = ~port_four_direction_reg[PORT_WIDTH-1:0];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_reg      <= 1'b0;
         port_out_reg <= '0;
         port_oe_reg  <= '0;
      end else begin
         pin_reg      <= pin_next;
         port_out_reg <= port_out_next;
         port_oe_reg  <= port_oe_next;
      end
   end

   assign bus_rdata        = rdata_reg;
   assign match_interrupt  = irq_reg;
   assign timer_output_pin = pin_reg;
   assign port_four_out    = port_out_reg;
   assign port_four_oe     = port_oe_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   duty_write_a: assert property (
      bus_wr && bus_addr == ADDR_DUTY |=> duty_compare_reg == $past(bus_wdata))
      else $error("duty compare did not take the written value");

   stop_clears_a: assert property (
      !run |=> counter_reg == 8'h00 && !match_interrupt && !out_active_reg)
      else $error("stopped timer not cleared");

   interval_match_a: assert property (
      state_reg == run_counting && count_tick && !pwm_mode && run && cycle_match
      |=> counter_reg == 8'h00 && match_interrupt)
      else $error("interval match did not clear and interrupt");

   square_toggle_a: assert property (
      state_reg == run_counting && count_tick && !pwm_mode && run && cycle_match
      && timer_mode_control_reg[GATE_BIT] && !bus_wr
      |=> timer_output_pin != $past(timer_output_pin))
      else $error("square wave did not toggle");

   pwm_cycle_a: assert property (
      state_reg == run_counting && count_tick && pwm_mode && run && cycle_match
      |=> out_active_reg && compare_duty_reg && counter_reg == 8'h00 && match_interrupt)
      else $error("pwm period match wrong");

   duty_match_a: assert property (
      state_reg == run_counting && count_tick && run && duty_match
      |=> !match_interrupt && !out_active_reg && !compare_duty_reg
          && counter_reg == $past(counter_reg) + 8'h01)
      else $error("pwm duty match wrong");

   mask_first_a: assert property (
      state_reg == run_masked && count_tick && run
      |=> counter_reg == 8'h00 && !out_active_reg)
      else $error("first pwm count clock not masked");

   young_duty_a: assert property (
      duty_match && duty_age_reg != DUTY_XFER_TICKS
      |=> active_duty_reg == $past(active_duty_reg))
      else $error("duty transferred too early");

   idle_level_a: assert property (
      !timer_mode_control_reg[GATE_BIT] |=> timer_output_pin == $past(timer_mode_control_reg[LEVEL_BIT]))
      else $error("disabled pin not at default level");

   port_dir_a: assert property (
      1'b1 |=> port_four_oe == ~$past(port_four_direction_reg[PORT_WIDTH-1:0]))
      else $error("port direction not applied");

   start_count_a: assert property (
      state_reg == run_stopped && run && !pwm_mode |=> state_reg == run_counting)
      else $error("interval start did not begin counting");

   duty_collide_a: assert property (
      state_reg == run_counting && count_tick && run && duty_match && write_duty
      |=> active_duty_reg == $past(active_duty_reg))
      else $error("duty transferred despite a colliding write");

   stop_pin_a: assert property (
      !run |=> timer_output_pin == $past(timer_mode_control_reg[LEVEL_BIT]))
      else $error("stopped pin not at default level");

   div1_tick_a: assert property (
      run && $past(run) && timer_mode_control_reg[CKS_MSB:CKS_LSB] == CKS_DIV1 |-> count_tick)
      else $error("undivided count clock missing a tick");

endmodule

// >>> core/timer_pkg.sv
package timer_pkg;

   // register addresses on the cpu data port
   localparam logic [15:0] ADDR_CYCLE = 16'hff0e;
   localparam logic [15:0] ADDR_DUTY  = 16'hff0f;
   localparam logic [15:0] ADDR_MODE  = 16'hff70;
   localparam logic [15:0] ADDR_LAT   = 16'hff04;
   localparam logic [15:0] ADDR_DIR   = 16'hff24;

   // reset values
   localparam logic [7:0] CMP_RESET  = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET  = 8'hff;
   localparam logic [7:0] LAT_RESET  = 8'h00;

   // mode register fields
   localparam int RUN_BIT   = 7;
   localparam int CKS_MSB   = 6;
   localparam int CKS_LSB   = 4;
   localparam int OPM_MSB   = 3;
   localparam int OPM_LSB   = 2;
   localparam int LEVEL_BIT = 1;
   localparam int GATE_BIT  = 0;

   // count clock select codes
   localparam logic [2:0] CKS_DIV1    = 3'h0;
   localparam logic [2:0] CKS_DIV4    = 3'h1;
   localparam logic [2:0] CKS_DIV16   = 3'h2;
   localparam logic [2:0] CKS_DIV64   = 3'h3;
   localparam logic [2:0] CKS_DIV4096 = 3'h4;
   localparam logic [2:0] CKS_RL128   = 3'h5;

   // prescaler widths: log2 of the divide ratios
   localparam int PRESCALE_BITS = 12;
   localparam int RL_DIV_BITS   = 7;
   localparam int SHIFT_DIV4    = 2;
   localparam int SHIFT_DIV16   = 4;
   localparam int SHIFT_DIV64   = 6;
   localparam int SHIFT_DIV4096 = 12;

   // operation modes
   localparam logic [1:0] OPM_INTERVAL = 2'h0;
   localparam logic [1:0] OPM_PWM      = 2'h2;

   // count clocks a new duty value must age before it may transfer
   localparam logic [1:0] DUTY_XFER_TICKS = 2'h3;

   // port 4
   localparam int PORT_WIDTH = 6;
   localparam int TIMER_PIN  = 2;

   typedef enum logic [1:0] {
      run_stopped,
      run_masked,
      run_counting
   } run_state_e;

endpackage

// >>> test/tb_top.sv
`timescale 1ns/1ns

module tb_top;
   import timer_pkg::*;

   typedef struct {
      logic [7:0] mode;
      logic [7:0] cyc;
      logic [7:0] duty;
      int         per;
      int         high;
   } row_s;

   localparam logic [15:0] RA [5] = '{ADDR_CYCLE, ADDR_DUTY, ADDR_MODE, ADDR_DIR, 16'hff00};
   localparam logic [7:0]  RV [5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00};

   logic                  clk;
   logic                  rst_b;
   logic [15:0]           bus_addr;
   logic                  bus_wr;
   logic [7:0]            bus_wdata;
   logic                  bus_rd;
   logic                  rl_tick;
   logic [7:0]            bus_rdata;
   logic                  match_interrupt;
   logic                  timer_output_pin;
   logic [PORT_WIDTH-1:0] port_four_out;
   logic [PORT_WIDTH-1:0] port_four_oe;
   logic [1:0]            rl_cnt;
   logic [7:0]            rd;
   row_s                  rows [11];
   int                    error_cnt;
   int                    checks_done;
   int                    p1;
   int                    p2;
   int                    hi;
   int                    pre;
   int                    irqs;

   interval_pwm_timer_8bit i_dut (
      .clk              (clk),
      .rst_b            (rst_b),
      .bus_addr         (bus_addr),
      .bus_wr           (bus_wr),
      .bus_wdata        (bus_wdata),
      .bus_rd           (bus_rd),
      .rl_tick          (rl_tick),
      .bus_rdata        (bus_rdata),
      .match_interrupt  (match_interrupt),
      .timer_output_pin (timer_output_pin),
      .port_four_out    (port_four_out),
      .port_four_oe     (port_four_oe)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // slow oscillator stand-in: one pulse every 4 clocks keeps the /128 row short
   always @(posedge clk) begin
      if (!rst_b) begin
         rl_cnt  <= 2'h0;
         rl_tick <= 1'b0;
      end else begin
         rl_cnt  <= rl_cnt + 2'h1;
         rl_tick <= (rl_cnt == 2'h3);
      end
   end

   task automatic end_sim;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chki(input string n, input int e, input int g);
      checks_done++;
      if (g != e) begin
         error_cnt++;
         $display("FAIL %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr    <= 1'b0;
   endtask

   task automatic rdr(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd   <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      d = bus_rdata;
   endtask

   // waits for a first match, then times two full periods and counts high cycles
   task automatic measure(input logic lvl, output int pa, output int pb, output int h,
                          output int pr);
      int n;
      n  = 0;
      pr = 0;
      h  = 0;
      pa = 0;
      pb = 0;
      @(negedge clk);
      while (match_interrupt !== 1'b1 && n < 20000) begin
         if (timer_output_pin !== lvl) pr++;
         n++;
         @(negedge clk);
      end
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            if (timer_output_pin === 1'b1) h++;
            n++;
            @(negedge clk);
         end while (match_interrupt !== 1'b1 && n < 20000);
         if (k == 0) pa = n;
         else pb = n;
      end
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      end_sim();
   end

   initial begin
      rst_b       = 1'b0;
      bus_addr    = 16'h0000;
      bus_wr      = 1'b0;
      bus_wdata   = 8'h00;
      bus_rd      = 1'b0;
      error_cnt   = 0;
      checks_done = 0;
      rows = '{'{8'h81, 8'h02, 8'h00, 3, 3},      '{8'h91, 8'h02, 8'h01, 12, 12},
               '{8'ha1, 8'h01, 8'h00, 32, 32},    '{8'hb1, 8'h01, 8'h00, 128, 128},
               '{8'hc1, 8'h01, 8'h00, 8192, 8192}, '{8'hd1, 8'h01, 8'h00, 1024, 1024},
               '{8'h80, 8'h02, 8'h00, 3, 0},      '{8'h83, 8'hfe, 8'h00, 255, 255},
               '{8'h89, 8'h04, 8'h01, 5, 4},      '{8'h8b, 8'h04, 8'h01, 5, 6},
               '{8'h89, 8'hff, 8'h00, 256, 2}};
      repeat (19) @(posedge clk);
      @(negedge clk);
      chk8("oe in reset", 8'h00, {2'h0, port_four_oe});
      @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rdr(RA[i], rd);
         chk8("reset value", RV[i], rd);
      end
      wr(ADDR_CYCLE, 8'ha5);
      wr(ADDR_DUTY, 8'h5a);
      wr(16'hff01, 8'h77);
      rdr(ADDR_CYCLE, rd);
      chk8("cycle readback", 8'ha5, rd);
      rdr(ADDR_DUTY, rd);
      chk8("duty readback", 8'h5a, rd);
      rdr(16'hff01, rd);
      chk8("unmapped read", 8'h00, rd);
      wr(ADDR_DIR, 8'h3b);
      wr(ADDR_LAT, 8'h15);
      @(posedge clk);
      @(negedge clk);
      chk8("port oe", 8'h04, {2'h0, port_four_oe});
      chk8("port out", 8'h15, {2'h0, port_four_out});
      // pin shared with the latch: latch bit 2 must be low or it masks the timer
      wr(ADDR_LAT, 8'h00);
      foreach (rows[i]) begin
         wr(ADDR_MODE, rows[i].mode & 8'h7f);
         wr(ADDR_CYCLE, rows[i].cyc);
         wr(ADDR_DUTY, rows[i].duty);
         wr(ADDR_MODE, rows[i].mode);
         measure(rows[i].mode[LEVEL_BIT], p1, p2, hi, pre);
         chki("period first", rows[i].per, p1);
         chki("period second", rows[i].per, p2);
         chki("active cycles", rows[i].high, hi);
         chki("early active", 0, pre);
         wr(ADDR_MODE, rows[i].mode & 8'h7f);
         @(posedge clk);
         irqs = 0;
         repeat (20) begin
            @(negedge clk);
            if (match_interrupt !== 1'b0) irqs++;
         end
         chki("irq after stop", 0, irqs);
         chk8("pin after stop", {7'h0, rows[i].mode[LEVEL_BIT]}, {7'h0, timer_output_pin});
      end
      wr(ADDR_MODE, 8'h02);
      @(posedge clk);
      @(negedge clk);
      chk8("pin level high", 8'h01, {7'h0, timer_output_pin});
      wr(ADDR_MODE, 8'h09);
      wr(ADDR_CYCLE, 8'h09);
      wr(ADDR_DUTY, 8'h01);
      wr(ADDR_MODE, 8'h89);
      measure(1'b0, p1, p2, hi, pre);
      chki("old duty", 4, hi);
      // written on the duty match cycle: transfer may slip one period behind the age limit
      wr(ADDR_DUTY, 8'h04);
      measure(1'b0, p1, p2, hi, pre);
      measure(1'b0, p1, p2, hi, pre);
      chki("new duty", 10, hi);
      chki("pwm period", 10, p2);
      rdr(ADDR_DUTY, rd);
      chk8("duty held", 8'h04, rd);
      wr(ADDR_MODE, 8'h09);
      end_sim();
   end

endmodule
